// *** src/lpc_fifo.sv ***
/*
  Small first-in first-out buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset; DEPTH must be a
  power of two of at least two.
*/
`default_nettype none

module lpc_fifo #(
  parameter int unsigned WIDTH = lpc_pkg::RES_BITS,
  parameter int unsigned DEPTH = lpc_pkg::BUF_DEPTH
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  import lpc_pkg::*;

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // Pointer wrap relies on a power-of-two depth.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_param
    $error("lpc_fifo: DEPTH must be a power of two >= 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } lpc_fifo_state_type;

  lpc_fifo_state_type f_q;
  lpc_fifo_state_type f_d;
  logic               push;
  logic               pop;

  // Honest flags straight from the occupancy count.
  assign in_ready  = (f_q.cnt != (PW + 1)'(DEPTH));
  assign out_valid = (f_q.cnt != '0);
  assign out_data  = f_q.mem[f_q.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Next state; push and pop in one cycle leave the count unchanged.
  always_comb begin
    f_d = f_q;
    if (push) begin
      f_d.mem[f_q.wp] = in_data;
      f_d.wp          = f_q.wp + PW'(1);
    end
    if (pop) begin
      f_d.rp = f_q.rp + PW'(1);
    end
    if (push && !pop) begin
      f_d.cnt = f_q.cnt + (PW + 1)'(1);
    end else if (pop && !push) begin
      f_d.cnt = f_q.cnt - (PW + 1)'(1);
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

endmodule // lpc_fifo

`default_nettype wire

// *** src/lpc_pkg.sv ***
/*
  Shared constants and types for the low-power conversion sequencer:
  clock rates, derived cycle counts, pin positions in the synchroniser
  vector and the sequencer state enumeration.
  Assumes the core clock runs at CLK_HZ and that every user of these
  numbers imports this package rather than restating them.
*/
`default_nettype none

package lpc_pkg;

  // Core clock and internal conversion clock.
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_MHZ       = CLK_HZ / 1_000_000;
  localparam int unsigned INT_CLK_HZ    = 40_000;

  // Result width and buffer depth defaults.
  localparam int unsigned RES_BITS      = 12;
  localparam int unsigned BUF_DEPTH     = 2;

  // One successive-approximation decision per internal clock period.
  localparam int unsigned BIT_CYC       = CLK_HZ / INT_CLK_HZ;
  // Clock output high time, half of the internal clock period.
  localparam int unsigned CLKO_HIGH_CYC = BIT_CYC / 2;

  // Analog settling time in interrupt power mode, rounded up to cycles.
  localparam int unsigned STAB_NS       = 50_000;
  localparam int unsigned STAB_CYC      = (STAB_NS * CLK_MHZ + 999) / 1000;

  // Throughput ceilings, rounded down to cycles.
  localparam int unsigned THRU_CONT_NS  = 305_000;
  localparam int unsigned THRU_INT_NS   = 350_000;
  localparam int unsigned THRU_CONT_CYC = (THRU_CONT_NS * CLK_MHZ) / 1000;
  localparam int unsigned THRU_INT_CYC  = (THRU_INT_NS * CLK_MHZ) / 1000;

  // Positions of the host pins in the synchroniser vector.
  localparam int unsigned PIN_START     = 0;
  localparam int unsigned PIN_MODE      = 1;
  localparam int unsigned PIN_BIP       = 2;
  localparam int unsigned PIN_TWOS      = 3;
  localparam int unsigned PIN_COMP      = 4;
  localparam int unsigned NPINS         = 5;

  // Reset levels of the status and power outputs.
  localparam logic        RST_EOC       = 1'h0;
  localparam logic        RST_PWR       = 1'h0;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_SETTLE,
    ST_CONVERT
  } lpc_state_type;

endpackage : lpc_pkg

`default_nettype wire

// *** src/lpc_sequencer.sv ***
/*
  Digital sequencer of a 12-bit low-power successive-approximation
  converter: start detection, analog power control, settling wait,
  bit-by-bit decisions, parallel and serial result pins, clock output,
  and a buffered word stream handed across to the link clock domain.
  Assumes the host pins and the comparator are asynchronous to clk, the
  link clock runs while results are drained, and the analog section
  answers dac_code through comp_in (high means input at or above trial).
*/
`default_nettype none


module lpc_sequencer #(
  parameter int unsigned RES_W      = lpc_pkg::RES_BITS,
  parameter int unsigned FIFO_DEPTH = lpc_pkg::BUF_DEPTH
) (
  // Core clock and reset.
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Host control pins.
  input  wire logic             start_convert,
  input  wire logic             power_mode,
  input  wire logic             bipolar_sel,
  input  wire logic             twos_comp_sel,
  // Analog section.
  input  wire logic             comp_in,
  output logic                  analog_power_en,
  output logic [RES_W-1:0]      dac_code,
  // Result pins.
  output logic                  eoc,
  output logic [RES_W-1:0]      par_data,
  output logic                  ser_data,
  output logic                  clk_out,
  // Link side word stream.
  input  wire logic             link_clk,
  input  wire logic             res_ready,
  output logic                  res_valid,
  output logic [RES_W-1:0]      res_data
);
  import lpc_pkg::*;

  localparam int unsigned CNT_W  = $clog2(STAB_CYC + BIT_CYC + 1);
  localparam int unsigned BIDX_W = $clog2(RES_W);

  // The timing budget must still close for the chosen width.
  if (RES_W < 2 || FIFO_DEPTH < 2
      || RES_W * BIT_CYC > THRU_CONT_CYC
      || STAB_CYC + RES_W * BIT_CYC > THRU_INT_CYC) begin : g_bad_param
    $error("lpc_sequencer: parameters break the throughput budget");
  end

  // All state of the core clock domain. p1 to p3 and pin filter the host
  // pins, st, cnt and bidx pace the sequence, sar and dac hold the trial,
  // pwr to clko are the registered pins, wr feeds the buffer, and pend,
  // req_tgl, hold, a1 to a3 and ack_seen carry the toggle hand-over.
  typedef struct packed {
    logic [NPINS-1:0] p1;
    logic [NPINS-1:0] p2;
    logic [NPINS-1:0] p3;
    logic [NPINS-1:0] pin;
    lpc_state_type    st;
    logic [CNT_W-1:0] cnt;
    logic [BIDX_W-1:0] bidx;
    logic [RES_W-1:0] sar;
    logic [RES_W-1:0] dac;
    logic             pwr;
    logic             eoc;
    logic [RES_W-1:0] par;
    logic             ser;
    logic             clko;
    logic [CNT_W-1:0] clko_cnt;
    logic             wr;
    logic [RES_W-1:0] wr_data;
    logic             pend;
    logic             req_tgl;
    logic [RES_W-1:0] hold;
    logic             a1;
    logic             a2;
    logic             a3;
    logic             ack_seen;
  } lpc_core_type;

  // All state of the link clock domain. rs1 to rs3 and rst carry reset
  // across, r1 to r3 the request toggle; vld and data are the stream pins.
  typedef struct packed {
    logic             rs1;
    logic             rs2;
    logic             rs3;
    logic             rst;
    logic             r1;
    logic             r2;
    logic             r3;
    logic             req_seen;
    logic             vld;
    logic [RES_W-1:0] data;
    logic             ack_tgl;
  } lpc_link_type;

  lpc_core_type     c_q;
  lpc_core_type     c_d;
  lpc_link_type     l_q;
  lpc_link_type     l_d;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic             fifo_out_ready;
  logic [RES_W-1:0] fifo_out_data;

  // Two-entry result buffer. Its in_ready gates new starts, so a host that
  // stops draining stalls conversions instead of losing words, except for the word
  // of a start taken in the cycle that the previous word fills the last entry.
  lpc_fifo #(
    .WIDTH (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (c_q.wr),
    .in_ready  (fifo_in_ready),
    .in_data   (c_q.wr_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // The handshake holds one word at a time; a new one leaves only after ack.
  // A stalled link therefore holds one word at the link and two in the buffer.
  assign fifo_out_ready = ~c_q.pend;

  // Core domain next state. Timing of one conversion, counted from the
  // edge E that accepts a start: continuous mode enters the decision loop
  // at E, interrupt mode first waits STAB_CYC cycles with power applied.
  // Each decision then takes BIT_CYC cycles, so status falls at
  // E + RES_W * BIT_CYC plus any settling time, and the elaboration check
  // keeps that inside the throughput ceiling. The pin stages add a few
  // cycles before E that the host sees but the ceiling does not count,
  // so a host with a tight budget must allow for them.
  always_comb begin
    logic [NPINS-1:0] agree;
    logic             start_rise;
    logic             decide;
    logic             keep;
    logic [RES_W-1:0] bitmask;
    logic [RES_W-1:0] code;
    logic [RES_W-1:0] msb;
    agree      = '0;
    start_rise = 1'h0;
    decide     = 1'h0;
    keep       = 1'h0;
    bitmask    = '0;
    code       = '0;
    msb        = '0;
    c_d        = c_q;

    // Three-stage pin synchroniser; a level is accepted once stages two
    // and three agree, which filters a single-cycle metastable glitch.
    c_d.p1  = {comp_in, twos_comp_sel, bipolar_sel, power_mode, start_convert};
    c_d.p2  = c_q.p1;
    c_d.p3  = c_q.p2;
    agree   = ~(c_q.p2 ^ c_q.p3);
    c_d.pin = (agree & c_q.p3) | (~agree & c_q.pin);

    // Rising edge of the accepted start level, seen in the same cycle that
    // the level is accepted so no settling time is lost.
    start_rise = agree[PIN_START] & c_q.p3[PIN_START] & ~c_q.pin[PIN_START];

    msb     = {1'h1, {(RES_W - 1){1'h0}}};
    bitmask = msb >> c_q.bidx;
    decide  = (c_q.st == ST_CONVERT) && (c_q.cnt == CNT_W'(BIT_CYC - 1));
    keep    = c_q.pin[PIN_COMP];
    code    = keep ? c_q.sar | bitmask : c_q.sar;
    c_d.wr  = 1'h0;

    // Clock output pulse stretcher, restarted at each decision. The pulse is
    // high for half the decision period; a full-period pulse would never fall.
    if (c_q.clko_cnt != '0) begin
      c_d.clko_cnt = c_q.clko_cnt - CNT_W'(1);
    end
    c_d.clko = (c_q.clko_cnt > CNT_W'(1));

    unique case (c_q.st)
      ST_STANDBY: begin
        // Power follows the mode pin: held high keeps analog powered.
        c_d.pwr = c_q.pin[PIN_MODE];
        // Starts while status is high never reach here; a start while the
        // buffer is full is dropped since its word would have nowhere to go.
        if (start_rise && fifo_in_ready) begin
          c_d.eoc  = 1'h1;
          c_d.sar  = '0;
          c_d.dac  = msb;
          c_d.bidx = '0;
          c_d.cnt  = '0;
          if (c_q.pin[PIN_MODE]) begin
            c_d.st = ST_CONVERT;
          end else begin
            c_d.pwr = 1'h1;
            c_d.st  = ST_SETTLE;
          end
        end
      end
      ST_SETTLE: begin
        // Wait for the analog section to stabilise before the first trial.
        if (c_q.cnt == CNT_W'(STAB_CYC - 1)) begin
          c_d.cnt = '0;
          c_d.st  = ST_CONVERT;
        end else begin
          c_d.cnt = c_q.cnt + CNT_W'(1);
        end
      end
      ST_CONVERT: begin
        // Start edges are not examined in this state, so they are ignored.
        c_d.cnt = c_q.cnt + CNT_W'(1);
        if (decide) begin
          c_d.cnt      = '0;
          c_d.sar      = code;
          c_d.ser      = keep;
          c_d.clko     = 1'h1;
          c_d.clko_cnt = CNT_W'(CLKO_HIGH_CYC);
          if (c_q.bidx == BIDX_W'(RES_W - 1)) begin
            // Status falls with the last decision; throughput closes here.
            c_d.st  = ST_STANDBY;
            c_d.eoc = 1'h0;
            c_d.pwr = c_q.pin[PIN_MODE];
            c_d.dac = code;
            // Raw code is straight or offset binary; zero input gives all
            // zeros or the midscale code without further work.
            if (c_q.pin[PIN_BIP] && c_q.pin[PIN_TWOS]) begin
              c_d.par = code ^ msb;
            end else begin
              c_d.par = code;
            end
            // The link word is the parallel result, coded the same way.
            c_d.wr      = 1'h1;
            c_d.wr_data = c_d.par;
          end else begin
            c_d.bidx = c_q.bidx + BIDX_W'(1);
            c_d.dac  = code | (bitmask >> 1);
          end
        end
      end
      default: begin
        c_d.st = ST_STANDBY;
      end
    endcase

    // Acknowledge toggle from the link domain frees the hand-over word.
    c_d.a1 = l_q.ack_tgl;
    c_d.a2 = c_q.a1;
    c_d.a3 = c_q.a2;
    if (c_q.pend && (c_q.a2 == c_q.a3) && (c_q.a3 != c_q.ack_seen)) begin
      c_d.ack_seen = c_q.a3;
      c_d.pend     = 1'h0;
    end else if (!c_q.pend && fifo_out_valid) begin
      // Hold stays fixed while pend is set, so the link samples it safely.
      c_d.hold    = fifo_out_data;
      c_d.req_tgl = ~c_q.req_tgl;
      c_d.pend    = 1'h1;
    end
  end

  // Core domain register with synchronous reset. The state field is set
  // by name as well so the reset state does not hang on its encoding.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      c_q     <= '0;
      c_q.st  <= ST_STANDBY;
      c_q.eoc <= RST_EOC;
      c_q.pwr <= RST_PWR;
    end else begin
      c_q <= c_d;
    end
  end

  // Link domain next state: request toggle in, word out, ack toggle back.
  // Only one bit crosses each way and each toggles once per word, so the
  // three-stage chains suffice; the word itself is read from hold, which
  // the core side keeps still from the toggle until the ack comes back.
  always_comb begin
    l_d     = l_q;
    l_d.rs1 = sys_rst;
    l_d.rs2 = l_q.rs1;
    l_d.rs3 = l_q.rs2;
    // Reset counts once stages two and three agree, as for the host pins.
    if (l_q.rs2 == l_q.rs3) begin
      l_d.rst = l_q.rs3;
    end
    l_d.r1  = c_q.req_tgl;
    l_d.r2  = l_q.r1;
    l_d.r3  = l_q.r2;
    if (l_q.vld && res_ready) begin
      l_d.vld     = 1'h0;
      l_d.ack_tgl = ~l_q.ack_tgl;
    end else if (!l_q.vld && (l_q.r2 == l_q.r3) && (l_q.r3 != l_q.req_seen)) begin
      l_d.req_seen = l_q.r3;
      l_d.vld      = 1'h1;
      l_d.data     = c_q.hold;
    end
    // Reset reaches this domain through its own synchroniser; the chains
    // keep shifting so they track the core toggles coming out of reset.
    if (l_q.rst) begin
      l_d.req_seen = 1'h0;
      l_d.vld      = 1'h0;
      l_d.data     = '0;
      l_d.ack_tgl  = 1'h0;
    end
  end

  // Link domain register. It has no reset term: reset arrives through the
  // synchronised rst field, so the link clock must run while sys_rst is
  // held for the stream outputs to clear.
  always_ff @(posedge link_clk) begin
    l_q <= l_d;
  end

  // Every output comes straight from a flip-flop. dac_code moves only at a
  // start and at decisions, so the comparator has a whole period to settle.
  assign analog_power_en = c_q.pwr;
  assign dac_code        = c_q.dac;
  assign eoc             = c_q.eoc;
  assign par_data        = c_q.par;
  assign ser_data        = c_q.ser;
  assign clk_out         = c_q.clko;
  assign res_valid       = l_q.vld;
  assign res_data        = l_q.data;

endmodule // lpc_sequencer

`default_nettype wire

// *** verification/lpc_host_model.sv ***
/* Far side: a comparator answering trial codes and a link receiver.
   Assumes target is held steady through each conversion. */
`default_nettype none

module lpc_host_model (
  // Clocks and reset.
  input  wire logic        clk,
  input  wire logic        link_clk,
  input  wire logic        sys_rst,
  // Analog stand-in.
  input  wire logic [11:0] target,
  input  wire logic        analog_power_en,
  input  wire logic [11:0] dac_code,
  output logic             comp_in,
  // Link receiver.
  input  wire logic        stall,
  input  wire logic        res_valid,
  input  wire logic [11:0] res_data,
  output logic             res_ready,
  output logic [11:0]      words [16],
  output int               n_words
);
  timeunit 1ns;
  timeprecision 100ps;
  logic junk_q;

  // An unpowered comparator answers nothing, so it shows a level that keeps changing.
  always_ff @(posedge clk) junk_q <= sys_rst ? 1'h0 : ~junk_q;
  assign comp_in = analog_power_en ? (target >= dac_code) : junk_q;

  // A word is taken at each edge where valid meets ready; stall holds ready off.
  always_ff @(posedge link_clk) begin
    if (sys_rst) begin
      res_ready <= 1'h0;
      n_words   <= 0;
    end else begin
      res_ready <= ~stall;
      if (res_valid && res_ready) begin
        words[n_words[3:0]] <= res_data;
        n_words             <= n_words + 1;
      end
    end
  end
endmodule // lpc_host_model

`default_nettype wire

// *** verification/lpc_sequencer_chk.sv ***
/* Pin-level assertions for the conversion sequencer, bound to its top.
   Assumes power_mode is held steady from before a request until its result. */
`default_nettype none

module lpc_sequencer_chk
  import lpc_pkg::*;
#(
  parameter int unsigned RES_W = 12
) (
  // Core side.
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire logic             start_convert,
  input wire logic             power_mode,
  input wire logic             bipolar_sel,
  input wire logic             twos_comp_sel,
  input wire logic             comp_in,
  input wire logic             analog_power_en,
  input wire logic [RES_W-1:0] dac_code,
  input wire logic             eoc,
  input wire logic [RES_W-1:0] par_data,
  input wire logic             ser_data,
  input wire logic             clk_out,
  // Link side.
  input wire logic             link_clk,
  input wire logic             res_ready,
  input wire logic             res_valid,
  input wire logic [RES_W-1:0] res_data
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned run_q;
  int unsigned hi_q;
  logic        mode_q;

  // Cycles spent converting and with the clock pin high; counts beat long repetitions.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_q  <= 0;
      hi_q   <= 0;
      mode_q <= 1'h0;
    end else begin
      run_q <= eoc ? run_q + 1 : 0;
      hi_q  <= clk_out ? hi_q + 1 : 0;
      if ($rose(eoc)) mode_q <= power_mode;
    end
  end

  AST_CONV_LEN: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(eoc) |-> run_q == RES_W * BIT_CYC + (mode_q ? 0 : STAB_CYC))
    else $error("conversion length wrong");
  AST_DAC_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(eoc) |-> dac_code == (1 << (RES_W - 1)) && analog_power_en)
    else $error("first trial code or power wrong");
  AST_PAR_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(par_data) |-> $fell(eoc))
    else $error("parallel data moved outside status fall");
  AST_PWR_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    (!eoc && !power_mode) [*6] |-> !analog_power_en)
    else $error("analog powered in standby");
  AST_PWR_CONT: assert property (@(posedge clk) disable iff (sys_rst)
    power_mode [*8] |-> analog_power_en)
    else $error("analog unpowered in continuous mode");
  AST_CLK_PHASE: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(clk_out) |-> run_q % BIT_CYC == 0 && run_q >= BIT_CYC + (mode_q ? 0 : STAB_CYC))
    else $error("clock pulse off the decision grid");
  AST_CLK_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(clk_out) |-> hi_q == CLKO_HIGH_CYC)
    else $error("clock pulse width wrong");
  AST_SER_AT_CLK: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(ser_data) |-> $rose(clk_out))
    else $error("serial bit moved between decisions");
  AST_VALID_HOLD: assert property (@(posedge link_clk) disable iff (sys_rst)
    res_valid && !res_ready |=> res_valid && $stable(res_data))
    else $error("word dropped while stalled");
endmodule // lpc_sequencer_chk

bind lpc_sequencer lpc_sequencer_chk #(.RES_W(RES_W)) i_chk (
  .clk(clk), .sys_rst(sys_rst), .start_convert(start_convert), .power_mode(power_mode),
  .bipolar_sel(bipolar_sel), .twos_comp_sel(twos_comp_sel), .comp_in(comp_in),
  .analog_power_en(analog_power_en), .dac_code(dac_code), .eoc(eoc), .par_data(par_data),
  .ser_data(ser_data), .clk_out(clk_out), .link_clk(link_clk), .res_ready(res_ready),
  .res_valid(res_valid), .res_data(res_data));

`default_nettype wire

// *** verification/lpc_sequencer_tb_top.sv ***
/* Bench: corner and random conversions in both power modes, then a stalled
   link fills the buffer until a request is refused. Checker binds itself. */
`default_nettype none

module lpc_sequencer_tb_top import lpc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'h0, link_clk = 1'h0, sys_rst = 1'h1, stall = 1'h0;
  logic        start_convert = 1'h0, power_mode = 1'h1, bipolar_sel = 1'h0;
  logic        twos_comp_sel = 1'h0;
  logic [11:0] target = 12'h000;
  logic        comp_in, analog_power_en, eoc, ser_data, clk_out, res_ready, res_valid;
  logic [11:0] dac_code, par_data, res_data, words [16], exp_w [16];
  int          n_words, n_exp = 0, bad_count = 0, n_compared = 0;
  logic [31:0] seed = 32'h8E87;

  // Link clock starts off phase so edges never line up with the core clock.
  initial forever #25 clk = ~clk;
  initial begin
    #3;
    forever #7.5 link_clk = ~link_clk;
  end

  lpc_sequencer i_dut (.clk(clk), .sys_rst(sys_rst), .start_convert(start_convert),
    .power_mode(power_mode), .bipolar_sel(bipolar_sel), .twos_comp_sel(twos_comp_sel),
    .comp_in(comp_in), .analog_power_en(analog_power_en), .dac_code(dac_code), .eoc(eoc),
    .par_data(par_data), .ser_data(ser_data), .clk_out(clk_out), .link_clk(link_clk),
    .res_ready(res_ready), .res_valid(res_valid), .res_data(res_data));
  lpc_host_model i_host (.clk(clk), .link_clk(link_clk), .sys_rst(sys_rst),
    .target(target), .analog_power_en(analog_power_en), .dac_code(dac_code),
    .comp_in(comp_in), .stall(stall), .res_valid(res_valid), .res_data(res_data),
    .res_ready(res_ready), .words(words), .n_words(n_words));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Two's complement is offset binary with the top bit turned over.
  function automatic logic [11:0] coded(input logic [11:0] t, input logic bip, tw);
    return (bip && tw) ? {~t[11], t[10:0]} : t;
  endfunction

  task automatic summarize;
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk12(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk12(what, {11'h000, exp}, {11'h000, got});
  endtask

  // One request; with again set, a second pulse lands mid-conversion and must do nothing.
  task automatic conv(input logic [11:0] t, input logic pm, bip, tw, again, output bit took);
    logic [11:0] bits;
    logic        prev;
    int          n;
    bits = 12'h000;
    prev = 1'h0;
    n = 0;
    took = 0;
    target = t;
    power_mode = pm;
    bipolar_sel = bip;
    twos_comp_sel = tw;
    repeat (10) @(negedge clk);
    start_convert = 1'h1;
    for (int i = 0; i < 9000 && !(took && !eoc); i++) begin
      @(negedge clk);
      if (i == (pm ? 100 : 2000)) start_convert = 1'h0;
      if (again && i == 3000) start_convert = 1'h1;
      if (again && i == 3100) start_convert = 1'h0;
      if (clk_out && !prev) begin
        bits = {bits[10:0], ser_data};
        n++;
      end
      prev = clk_out;
      if (eoc) took = 1;
      if (!took && i == 150) return;
    end
    if (eoc) begin
      chk1("status fall", 1'h0, eoc);
      summarize;
    end
    chk12("parallel result", coded(t, bip, tw), par_data);
    chk12("serial decisions", t, bits);
    chk12("decision count", 12'h00C, n[11:0]);
    chk1("analog power in standby", pm, analog_power_en);
    exp_w[n_exp[3:0]] = coded(t, bip, tw);
    n_exp++;
    repeat (400) @(negedge clk);
  endtask

  // Wait for the link to deliver every expected word, then compare them in order.
  task automatic drain;
    for (int i = 0; i < 3000 && n_words != n_exp; i++) @(negedge clk);
    chk12("words delivered", n_exp[11:0], n_words[11:0]);
    for (int k = 0; k < n_exp; k++) chk12("link word", exp_w[k], words[k]);
  endtask

  initial begin
    bit ok;
    int acc;
    repeat (12) @(negedge clk);
    sys_rst = 1'h0;
    repeat (10) @(negedge clk);
    chk1("status after reset", 1'h0, eoc);
    conv(12'h000, 1'h1, 1'h0, 1'h0, 1'h0, ok);
    chk1("request taken", 1'h1, ok);
    conv(12'h800, 1'h0, 1'h1, 1'h0, 1'h1, ok);
    chk1("request taken", 1'h1, ok);
    conv(12'hFFF, 1'h1, 1'h1, 1'h1, 1'h1, ok);
    chk1("request taken", 1'h1, ok);
    drain;
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      conv(seed[11:0], seed[12], seed[13], seed[14], 1'h0, ok);
      chk1("request taken", 1'h1, ok);
    end
    drain;
    // A stalled receiver must lose no word; requests are refused once the buffer is full.
    stall = 1'h1;
    acc = 0;
    ok = 1;
    for (int i = 0; i < 5 && ok; i++) begin
      seed = lfsr(seed);
      conv(seed[11:0], 1'h1, 1'h0, 1'h0, 1'h0, ok);
      if (ok) acc++;
    end
    chk1("request refused when full", 1'h0, ok);
    // Two buffer entries plus the word waiting at the stalled link.
    chk12("words held while stalled", 12'(BUF_DEPTH + 1), acc[11:0]);
    stall = 1'h0;
    drain;
    summarize;
  end
endmodule // lpc_sequencer_tb_top

`default_nettype wire
